// file: core/cfsic_pkg.sv
package cfsic_pkg;

   // sizes
   localparam int unsigned REG_COUNT = 32;
   localparam int unsigned IRQ_COUNT = 8;
   localparam int unsigned IRQ_IDX_W = 3;

   // register offsets in the i/o space
   localparam logic [5:0] IO_SP_LOW  = 6'h3d;
   localparam logic [5:0] IO_SP_HIGH = 6'h3e;
   localparam logic [5:0] IO_FLAGS   = 6'h3f;

   // reset values
   localparam logic [7:0]  FLAGS_RESET = 8'h00;
   localparam logic [15:0] SP_RESET    = 16'h0000;

   // flag register bit positions
   localparam int unsigned BIT_GIE   = 7;
   localparam int unsigned BIT_TCOPY = 6;
   localparam int unsigned BIT_HALF  = 5;
   localparam int unsigned BIT_SIGN  = 4;
   localparam int unsigned BIT_OVF   = 3;
   localparam int unsigned BIT_NEG   = 2;
   localparam int unsigned BIT_ZERO  = 1;
   localparam int unsigned BIT_CARRY = 0;

   // register file layout and data-space window
   localparam logic [4:0]  PTR_BASE_REG  = 5'h1a;
   localparam logic [4:0]  PAIR_HIGH     = 5'h01;
   localparam logic [15:0] REG_SPACE_TOP = 16'h0020;

   // stack steps
   localparam logic [15:0] SP_STEP_BYTE = 16'h0001;
   localparam logic [15:0] SP_STEP_ADDR = 16'h0002;

   // program memory vectors (word addresses)
   localparam logic [14:0] RESET_VEC  = 15'h0000;
   localparam logic [14:0] BOOT_START = 15'h7000;
   localparam logic [14:0] VEC_STRIDE = 15'h0002;

   // interrupt entry timing in core clocks
   localparam logic [2:0] PUSH_LAST = 3'h2;
   localparam logic [2:0] WAKE_LAST = 3'h3;

   typedef struct packed {
      logic half;
      logic ovf;
      logic neg;
      logic zero;
      logic carry;
   } cfsic_alu_flags_type;

   typedef struct packed {
      logic sei;
      logic cli;
      logic irq_return_insn;
      logic ret;
      logic call;
      logic push;
      logic pop;
      logic bit_store_insn;
      logic bit_load_insn;
      logic done;
   } cfsic_insn_type;

   typedef enum logic [1:0] {
      PTR_NONE    = 2'b00,
      PTR_DISP    = 2'b01,
      PTR_POSTINC = 2'b10,
      PTR_PREDEC  = 2'b11
   } cfsic_ptr_mode_type;

   typedef enum logic [1:0] {
      IRQ_IDLE = 2'b00,
      IRQ_WAKE = 2'b01,
      IRQ_PUSH = 2'b11,
      IRQ_JUMP = 2'b10
   } cfsic_irq_state_type;

endpackage

// file: core/cfsic_core_ctrl.sv
`timescale 1ns/1ps
// Overview of operation
// - no interrupt is served while the global enable flag bit 7 is clear
// - global enable cleared on interrupt entry, set by return-from-irq, set/clear instructions
// - bit store copies a register bit into bit 6; bit load writes it back
// - sign flag bit 4 always equals negative xor overflow
// - negative bit 2, zero bit 1, carry bit 0 follow alu results
// - half carry bit 5 and overflow bit 3 follow alu results
// - register file offers 8-bit and 16-bit operand and result ports
// - the 32 working registers occupy the lowest data-space addresses
// - top six registers form three 16-bit pointers: displacement, post-increment, pre-decrement
// - stack grows downward; push decrements by one, pop increments by one
// - call and interrupt entry decrement by two; both returns increment by two
// - stack pointer high at 0x3e, low at 0x3d, both read/write, reset zero
// - one clock, undivided; alu result written back within one cycle
// - each source owns a vector; lower vector means higher priority
// - relocate select moves irq vectors, fuse moves reset vector, to boot start
// - boot lock bits may suppress interrupts depending on program counter
// - flag sources: cleared on vectoring, write-one clears, kept while disabled
// - level sources request only while their condition is present
// - after return from interrupt one main instruction runs before another irq
// - clear-enable instruction blocks any interrupt, even one in the same cycle
// - after set-enable the next instruction runs before any pending interrupt
// - interrupt entry takes four cycles pushing the pc, four more when sleeping
module cfsic_core_ctrl
   import cfsic_pkg::*;
(
   // clock and reset
   input  wire logic                      clk,
   input  wire logic                      rstn,
   input  wire logic                      ce,
   // execution unit strobes
   input  wire cfsic_insn_type            insn,
   input  wire cfsic_alu_flags_type       alu_flags,
   input  wire cfsic_alu_flags_type       alu_flag_we,
   input  wire logic [2:0]                bit_sel,
   input  wire logic [14:0]               pc,
   input  wire logic                      sleeping,
   // register file ports
   input  wire logic [4:0]                rd_a_idx,
   input  wire logic [4:0]                rd_b_idx,
   output      logic [7:0]                rd_a,
   output      logic [7:0]                rd_b,
   output      logic [15:0]               rd_word,
   input  wire logic                      wr_en,
   input  wire logic                      wr_wide,
   input  wire logic [4:0]                wr_idx,
   input  wire logic [15:0]               wr_data,
   // index pointers and data space
   input  wire logic [1:0]                ptr_sel,
   input  wire cfsic_ptr_mode_type        ptr_mode,
   input  wire logic [5:0]                ptr_disp,
   output      logic [15:0]               ptr_addr,
   input  wire logic [15:0]               ds_addr,
   input  wire logic                      ds_wr,
   input  wire logic [7:0]                ds_wdata,
   output      logic                      ds_hit,
   output      logic [7:0]                ds_rdata,
   // i/o register port
   input  wire logic [5:0]                io_addr,
   input  wire logic                      io_wr,
   input  wire logic [7:0]                io_wdata,
   output      logic [7:0]                io_rdata,
   // interrupt sources
   input  wire logic [IRQ_COUNT-1:0]      irq_event,
   input  wire logic [IRQ_COUNT-1:0]      irq_level,
   input  wire logic [IRQ_COUNT-1:0]      irq_level_type,
   input  wire logic [IRQ_COUNT-1:0]      irq_enable,
   input  wire logic [IRQ_COUNT-1:0]      irq_flag_wr1c,
   output      logic [IRQ_COUNT-1:0]      irq_flag,
   // vector and lock controls
   input  wire logic                      vector_relocate_select,
   input  wire logic                      reset_vector_relocate_fuse,
   input  wire logic                      boot_lock_bit_a,
   input  wire logic                      boot_lock_bit_b,
   // state and entry outputs
   output      logic [7:0]                flag_register,
   output      logic [15:0]               stack_pointer,
   output      logic                      irq_busy,
   output      logic                      vector_load,
   output      logic [14:0]               vector_addr,
   output      logic [14:0]               reset_vector,
   output      logic                      stack_wr,
   output      logic [15:0]               stack_addr,
   output      logic [7:0]                stack_wdata
);

   // lowest index wins; returns {valid, index}
   function automatic logic [IRQ_IDX_W:0] pick_first(input logic [IRQ_COUNT-1:0] req);
      logic [IRQ_IDX_W:0] res;
      res = '0;
      for (int i = IRQ_COUNT - 1; i >= 0; i--) begin
         if (req[i]) begin
            res = {1'b1, IRQ_IDX_W'(i)};
         end
      end
      return res;
   endfunction

   logic [7:0]                regs [REG_COUNT];
   logic [7:0]                next_regs [REG_COUNT];
   logic [7:0]                flags, next_flags;
   logic [15:0]               sp, next_sp;
   logic [IRQ_COUNT-1:0]      flag_q, next_flag_q;
   cfsic_irq_state_type       state, next_state;
   logic [2:0]                cnt, next_cnt;
   logic                      hold, next_hold;
   logic [15:0]               entry_sp, next_entry_sp;
   logic [14:0]               entry_pc, next_entry_pc;
   logic [14:0]               next_vector_addr;
   logic                      next_vector_load, next_stack_wr;
   logic [15:0]               next_stack_addr;
   logic [7:0]                next_stack_wdata;
   logic [4:0]                ptr_lo;
   logic [15:0]               ptr_base, ptr_new;
   logic [IRQ_COUNT-1:0]      pending;
   logic [IRQ_IDX_W:0]        pick;
   logic [IRQ_IDX_W-1:0]      pick_idx;
   logic                      lock_block, take_now;

   // register file read side
   assign rd_a     = regs[rd_a_idx];
   assign rd_b     = regs[rd_b_idx];
   assign rd_word  = {regs[rd_a_idx | PAIR_HIGH], regs[rd_a_idx & ~PAIR_HIGH]};
   assign ds_hit   = ds_addr < REG_SPACE_TOP;
   assign ds_rdata = ds_hit ? regs[ds_addr[4:0]] : 8'h00;

   // pointer pair select; code 3 wraps onto registers 0 and 1
   assign ptr_lo   = PTR_BASE_REG + 5'({ptr_sel, 1'b0});
   assign ptr_base = {regs[ptr_lo | PAIR_HIGH], regs[ptr_lo]};
   assign ptr_new  = (ptr_mode == PTR_PREDEC) ? ptr_base - 16'h0001 : ptr_base + 16'h0001;
   always_comb begin
      unique case (ptr_mode)
         PTR_DISP:    ptr_addr = ptr_base + {10'h000, ptr_disp};
         PTR_PREDEC:  ptr_addr = ptr_new;
         PTR_POSTINC: ptr_addr = ptr_base;
         PTR_NONE:    ptr_addr = ptr_base;
      endcase
   end

   // register file write side, later sources win
   always_comb begin
      next_regs = regs;
      if (ptr_mode == PTR_POSTINC || ptr_mode == PTR_PREDEC) begin
         next_regs[ptr_lo]             = ptr_new[7:0];
         next_regs[ptr_lo | PAIR_HIGH] = ptr_new[15:8];
      end
      if (wr_en) begin
         next_regs[wr_idx] = wr_data[7:0];
         if (wr_wide) begin
            next_regs[wr_idx | PAIR_HIGH] = wr_data[15:8];
         end
      end
      if (ds_hit && ds_wr) begin
         next_regs[ds_addr[4:0]] = ds_wdata;
      end
      if (insn.bit_load_insn) begin
         next_regs[rd_a_idx][bit_sel] = flags[BIT_TCOPY];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < REG_COUNT; i++) begin
            regs[i] <= 8'h00;
         end
      end else if (ce) begin
         regs <= next_regs;
      end
   end

   // interrupt request selection
   assign pending  = (flag_q & ~irq_level_type | irq_level & irq_level_type) & irq_enable;
   assign pick     = pick_first(pending);
   assign pick_idx = pick[IRQ_IDX_W-1:0];
   // locked sections refuse interrupts while the pc sits inside them
   assign lock_block = (boot_lock_bit_a && pc < BOOT_START) || (boot_lock_bit_b && pc >= BOOT_START);
   // entry only at an instruction boundary; sei/cli/irq_return_insn themselves never yield
   assign take_now = ce && state == IRQ_IDLE && insn.done && flags[BIT_GIE] && !hold
                     && !insn.cli && !insn.sei && !insn.irq_return_insn && pick[IRQ_IDX_W] && !lock_block;

   assign reset_vector  = reset_vector_relocate_fuse ? BOOT_START : RESET_VEC;
   assign irq_busy      = state != IRQ_IDLE;
   assign flag_register = flags;
   assign stack_pointer = sp;
   assign irq_flag      = flag_q;

   always_comb begin
      unique case (io_addr)
         IO_SP_LOW:  io_rdata = sp[7:0];
         IO_SP_HIGH: io_rdata = sp[15:8];
         IO_FLAGS:   io_rdata = flags;
         default:    io_rdata = 8'h00;
      endcase
   end

   // flags, stack pointer and interrupt entry
   always_comb begin
      next_flags       = flags;
      next_sp          = sp;
      next_flag_q      = flag_q;
      next_state       = state;
      next_cnt         = cnt;
      next_hold        = hold;
      next_entry_sp    = entry_sp;
      next_entry_pc    = entry_pc;
      next_vector_addr = vector_addr;
      next_vector_load = 1'b0;
      next_stack_wr    = 1'b0;
      next_stack_addr  = stack_addr;
      next_stack_wdata = stack_wdata;

      if (alu_flag_we.half)  next_flags[BIT_HALF]  = alu_flags.half;
      if (alu_flag_we.ovf)   next_flags[BIT_OVF]   = alu_flags.ovf;
      if (alu_flag_we.neg)   next_flags[BIT_NEG]   = alu_flags.neg;
      if (alu_flag_we.zero)  next_flags[BIT_ZERO]  = alu_flags.zero;
      if (alu_flag_we.carry) next_flags[BIT_CARRY] = alu_flags.carry;
      if (insn.bit_store_insn) next_flags[BIT_TCOPY] = regs[rd_a_idx][bit_sel];
      if (io_wr && io_addr == IO_FLAGS) next_flags = io_wdata;
      if (insn.sei || insn.irq_return_insn) next_flags[BIT_GIE] = 1'b1;
      if (insn.cli) next_flags[BIT_GIE] = 1'b0;
      if (take_now) next_flags[BIT_GIE] = 1'b0;
      // sign is never stored independently
      next_flags[BIT_SIGN] = next_flags[BIT_NEG] ^ next_flags[BIT_OVF];

      if (insn.push) next_sp = sp - SP_STEP_BYTE;
      if (insn.pop) next_sp = sp + SP_STEP_BYTE;
      if (insn.call) next_sp = sp - SP_STEP_ADDR;
      if (insn.ret || insn.irq_return_insn) next_sp = sp + SP_STEP_ADDR;
      if (take_now) next_sp = next_sp - SP_STEP_ADDR;
      if (io_wr && io_addr == IO_SP_LOW) next_sp[7:0] = io_wdata;
      if (io_wr && io_addr == IO_SP_HIGH) next_sp[15:8] = io_wdata;

      // one instruction must complete after sei or irq_return_insn
      if (insn.done) next_hold = insn.sei || insn.irq_return_insn;

      // a new event beats a clear in the same cycle
      next_flag_q = flag_q & ~irq_flag_wr1c;
      if (take_now) next_flag_q[pick_idx] = 1'b0;
      next_flag_q = next_flag_q | (irq_event & ~irq_level_type);

      unique case (state)
         IRQ_IDLE: begin
            if (take_now) begin
               next_state       = sleeping ? IRQ_WAKE : IRQ_PUSH;
               next_cnt         = 3'h0;
               next_entry_sp    = sp;
               next_entry_pc    = pc;
               next_vector_addr = (vector_relocate_select ? BOOT_START : RESET_VEC)
                                  + 15'(({12'h000, pick_idx} + 15'h0001) * VEC_STRIDE);
            end
         end
         IRQ_WAKE: begin
            next_cnt = cnt + 3'h1;
            if (cnt == WAKE_LAST) begin
               next_state = IRQ_PUSH;
               next_cnt   = 3'h0;
            end
         end
         IRQ_PUSH: begin
            next_cnt = cnt + 3'h1;
            if (cnt == 3'h0) begin
               next_stack_wr    = 1'b1;
               next_stack_addr  = entry_sp;
               next_stack_wdata = entry_pc[7:0];
            end
            if (cnt == 3'h1) begin
               next_stack_wr    = 1'b1;
               next_stack_addr  = entry_sp - SP_STEP_BYTE;
               next_stack_wdata = {1'b0, entry_pc[14:8]};
            end
            if (cnt == PUSH_LAST) begin
               next_state       = IRQ_JUMP;
               next_vector_load = 1'b1;
            end
         end
         IRQ_JUMP: next_state = IRQ_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flags       <= FLAGS_RESET;
         sp          <= SP_RESET;
         flag_q      <= '0;
         state       <= IRQ_IDLE;
         cnt         <= 3'h0;
         hold        <= 1'b0;
         entry_sp    <= SP_RESET;
         entry_pc    <= RESET_VEC;
         vector_addr <= RESET_VEC;
         vector_load <= 1'b0;
         stack_wr    <= 1'b0;
         stack_addr  <= SP_RESET;
         stack_wdata <= 8'h00;
      end else if (ce) begin
         flags       <= next_flags;
         sp          <= next_sp;
         flag_q      <= next_flag_q;
         state       <= next_state;
         cnt         <= next_cnt;
         hold        <= next_hold;
         entry_sp    <= next_entry_sp;
         entry_pc    <= next_entry_pc;
         vector_addr <= next_vector_addr;
         vector_load <= next_vector_load;
         stack_wr    <= next_stack_wr;
         stack_addr  <= next_stack_addr;
         stack_wdata <= next_stack_wdata;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   gie_gate_a: assert property (!flags[BIT_GIE] |-> !take_now)
      else $error("interrupt taken with global enable clear");
   entry_clears_gie_a: assert property (take_now |=> !flags[BIT_GIE] && state != IRQ_IDLE)
      else $error("global enable not cleared on entry");
   cli_block_a: assert property (ce && insn.cli |-> !take_now ##1 !flags[BIT_GIE])
      else $error("interrupt taken alongside clear-enable");
   sign_xor_a: assert property (flag_register[BIT_SIGN] == (flag_register[BIT_NEG] ^ flag_register[BIT_OVF]))
      else $error("sign flag differs from negative xor overflow");
   push_step_a: assert property (ce && insn.push && !insn.pop && !insn.call && !insn.ret
                                 && !insn.irq_return_insn && !take_now && !io_wr |=> sp == $past(sp) - SP_STEP_BYTE)
      else $error("push did not step stack pointer down by one");
   call_step_a: assert property (ce && insn.call && !insn.ret && !insn.irq_return_insn && !take_now && !io_wr
                                 |=> sp == $past(sp) - SP_STEP_ADDR)
      else $error("call did not step stack pointer down by two");
   entry_len_a: assert property (take_now && !sleeping |=> (state != IRQ_IDLE)[*4])
      else $error("interrupt entry shorter than four cycles");
   sleep_len_a: assert property (take_now && sleeping |=> (state == IRQ_WAKE)[*4])
      else $error("wake extension shorter than four cycles");
   hold_block_a: assert property (ce && insn.done && (insn.sei || insn.irq_return_insn) |=> hold && !take_now)
      else $error("interrupt taken before one more instruction");
   vector_clear_a: assert property (take_now && !irq_level_type[pick_idx] && !irq_event[pick_idx]
                                    |=> !flag_q[$past(pick_idx)])
      else $error("taken source flag not cleared");

endmodule // cfsic_core_ctrl

// file: bench/cfsic_src_model.sv
`timescale 1ns/1ps
module cfsic_src_model
   import cfsic_pkg::*;
(
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rstn,
   // bench requests
   input  wire logic [IRQ_COUNT-1:0] fire,
   input  wire logic [IRQ_COUNT-1:0] cond,
   // core side
   input  wire logic                 done,
   input  wire logic                 vector_load,
   input  wire logic [14:0]          vector_addr,
   output      logic [IRQ_COUNT-1:0] irq_event,
   output      logic [IRQ_COUNT-1:0] irq_level,
   output      logic [14:0]          pc
);
   logic [IRQ_COUNT-1:0] next_irq_event;
   logic [IRQ_COUNT-1:0] next_irq_level;
   logic [14:0]          next_pc;
   // events last one clock only, a held line would refill a cleared flag
   always_comb begin
      next_irq_event = fire;
      next_irq_level = cond;
      next_pc        = pc;
      if (vector_load) begin
         next_pc = vector_addr;
      end else if (done) begin
         next_pc = pc + 15'h0001;
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_event <= '0;
         irq_level <= '0;
         pc        <= RESET_VEC;
      end else begin
         irq_event <= next_irq_event;
         irq_level <= next_irq_level;
         pc        <= next_pc;
      end
   end
endmodule // cfsic_src_model

// file: bench/cfsic_core_ctrl_test.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin miscompares++; \
   $display("[ERR] %0t got %0h expected %0h", $time, (got), (exp)); end end
module cfsic_core_ctrl_test
   import cfsic_pkg::*;
;
   localparam cfsic_insn_type I_DONE = 10'h001, I_BLD = 10'h003, I_BST = 10'h005, I_POP = 10'h009;
   localparam cfsic_insn_type I_PUSH = 10'h011, I_CALL = 10'h021, I_RET = 10'h041, I_IRQ_RETURN_INSN = 10'h081;
   localparam cfsic_insn_type I_CLI = 10'h101, I_SEI = 10'h201;
   logic                 clk, rstn, ce, sleeping, wr_en, wr_wide, ds_wr, io_wr, ds_hit, irq_busy, vector_load, stack_wr;
   logic                 vector_relocate_select, reset_vector_relocate_fuse, boot_lock_bit_a, boot_lock_bit_b;
   cfsic_insn_type       insn;
   cfsic_alu_flags_type  alu_flags, alu_flag_we;
   cfsic_ptr_mode_type   ptr_mode;
   logic [1:0]           ptr_sel;
   logic [2:0]           bit_sel;
   logic [4:0]           rd_a_idx, rd_b_idx, wr_idx, ef;
   logic [5:0]           ptr_disp, io_addr;
   logic [7:0]           rd_a, rd_b, ds_wdata, ds_rdata, io_wdata, io_rdata, flag_register, stack_wdata;
   logic [14:0]          pc, vector_addr, reset_vector, tv, mv;
   logic [15:0]          rd_word, wr_data, ptr_addr, ds_addr, stack_pointer, stack_addr, exp_sp;
   logic [23:0]          ms;
   logic [IRQ_COUNT-1:0] irq_event, irq_level, irq_level_type, irq_enable, irq_flag_wr1c, irq_flag, fire, cond;
   logic [14:0]          vq[$];
   logic [23:0]          sq[$];
   int                   cq[$];
   int                   cyc_n = 0, tc, mc, miscompares = 0, cmp_count = 0, seed = 50551;

   cfsic_core_ctrl uut (.clk, .rstn, .ce, .insn, .alu_flags, .alu_flag_we, .bit_sel, .pc, .sleeping, .rd_a_idx,
      .rd_b_idx, .rd_a, .rd_b, .rd_word, .wr_en, .wr_wide, .wr_idx, .wr_data, .ptr_sel, .ptr_mode, .ptr_disp,
      .ptr_addr, .ds_addr, .ds_wr, .ds_wdata, .ds_hit, .ds_rdata, .io_addr, .io_wr, .io_wdata, .io_rdata,
      .irq_event, .irq_level, .irq_level_type, .irq_enable, .irq_flag_wr1c, .irq_flag, .vector_relocate_select,
      .reset_vector_relocate_fuse, .boot_lock_bit_a, .boot_lock_bit_b, .flag_register, .stack_pointer,
      .irq_busy, .vector_load, .vector_addr, .reset_vector, .stack_wr, .stack_addr, .stack_wdata);
   cfsic_src_model src (.clk, .rstn, .fire, .cond, .done(insn.done), .vector_load, .vector_addr, .irq_event,
      .irq_level, .pc);

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic end_of_test();
      if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic tick(int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic io_put(logic [5:0] a, logic [7:0] d);
      {io_addr, io_wdata, io_wr} = {a, d, 1'b1};
      tick();
      io_wr = 1'b0;
      tick();
   endtask
   task automatic io_chk(logic [5:0] a, logic [7:0] d);
      io_addr = a;
      #1;
      `CHK(io_rdata, d)
   endtask
   task automatic wr_pair(logic [4:0] i, logic [15:0] d);
      {wr_en, wr_wide, wr_idx, wr_data} = {2'b11, i, d};
      tick();
      wr_en = 1'b0;
      tick();
   endtask
   task automatic pulse(logic [IRQ_COUNT-1:0] v);
      fire = v;
      tick();
      fire = '0;
      tick(2);
   endtask
   // src < 0: no entry may follow; else note vector, entry time and the two return bytes
   task automatic step(cfsic_insn_type i, int src);
      insn = i;
      if (src >= 0) begin
         tv = vector_relocate_select ? BOOT_START : RESET_VEC;
         vq.push_back(tv + 15'(src + 1) * VEC_STRIDE);
         cq.push_back(cyc_n + (sleeping ? 8 : 4));
         sq.push_back({exp_sp, pc[7:0]});
         sq.push_back({exp_sp - SP_STEP_BYTE, 1'b0, pc[14:8]});
         exp_sp = exp_sp - SP_STEP_ADDR;
      end
      tick();
      insn = '0;
      if (src >= 0) begin
         `CHK(flag_register[BIT_GIE], 1'b0)
         `CHK(stack_pointer, exp_sp)
         `CHK(irq_busy, 1'b1)
         for (tc = 0; tc < 12 && irq_busy !== 1'b0; tc++) tick();
      end
      tick();
   endtask

   // any entry or stack write without a note is a fault
   always @(posedge clk) begin
      cyc_n <= cyc_n + 1;
      if (rstn === 1'b1 && vector_load === 1'b1) begin
         mv = vq.size() ? vq.pop_front() : 15'h7fff;
         mc = cq.size() ? cq.pop_front() : -1;
         `CHK(vector_addr, mv)
         `CHK(cyc_n, mc)
      end
      if (rstn === 1'b1 && stack_wr === 1'b1) begin
         ms = sq.size() ? sq.pop_front() : 24'hxxxxxx;
         `CHK({stack_addr, stack_wdata}, ms)
      end
      if (cyc_n > 5000) begin
         miscompares++;
         $display("[ERR] %0t timeout", $time);
         end_of_test();
      end
   end

   initial begin
      {rstn, sleeping, wr_en, wr_wide, ds_wr, io_wr, vector_relocate_select, reset_vector_relocate_fuse} = '0;
      {boot_lock_bit_a, boot_lock_bit_b, insn, alu_flags, alu_flag_we, bit_sel, rd_a_idx, rd_b_idx} = '0;
      {wr_idx, wr_data, ptr_sel, ptr_disp, ds_addr, ds_wdata, io_addr, io_wdata, fire, cond} = '0;
      {irq_level_type, irq_enable, irq_flag_wr1c} = '0;
      ce = 1'b1;
      ptr_mode = PTR_NONE;
      repeat (2) @(posedge clk);
      #1 rstn = 1'b1;
      io_chk(IO_SP_LOW, 8'h00);
      io_chk(IO_SP_HIGH, 8'h00);
      io_chk(IO_FLAGS, FLAGS_RESET);
      io_chk(6'h10, 8'h00);
      `CHK(reset_vector, RESET_VEC)
      reset_vector_relocate_fuse = 1'b1;
      #1;
      `CHK(reset_vector, BOOT_START)
      reset_vector_relocate_fuse = 1'b0;
      io_put(IO_SP_LOW, 8'h80);
      io_put(IO_SP_HIGH, 8'h01);
      exp_sp = 16'h0180;
      io_chk(IO_SP_HIGH, 8'h01);
      step(I_PUSH, -1);
      `CHK(stack_pointer, exp_sp - SP_STEP_BYTE)
      step(I_POP, -1);
      `CHK(stack_pointer, exp_sp)
      step(I_CALL, -1);
      `CHK(stack_pointer, exp_sp - SP_STEP_ADDR)
      step(I_RET, -1);
      `CHK(stack_pointer, exp_sp)
      ce = 1'b0;
      step(I_PUSH, -1);
      ce = 1'b1;
      `CHK(stack_pointer, exp_sp)
      ef = '0;
      repeat (8) begin
         alu_flags = 5'($random(seed));
         alu_flag_we = 5'($random(seed));
         ef = (ef & ~alu_flag_we) | (alu_flags & alu_flag_we);
         tick();
         {alu_flags, alu_flag_we} = '0;
         `CHK(flag_register[5:0], {ef[4], ef[3] ^ ef[2], ef[3:0]})
         tick();
      end
      io_put(IO_FLAGS, 8'h10);
      `CHK(flag_register, 8'h00)
      wr_pair(5'h04, 16'($random(seed)));
      {rd_a_idx, rd_b_idx, ds_addr} = {5'h04, 5'h05, 16'h0005};
      #1;
      `CHK(rd_word, wr_data)
      `CHK({ds_hit, ds_rdata, rd_b}, {1'b1, wr_data[15:8], wr_data[15:8]})
      ds_addr = REG_SPACE_TOP;
      #1;
      `CHK(ds_hit, 1'b0)
      {ds_addr, ds_wdata, ds_wr, rd_a_idx} = {16'h001f, 8'h5a, 1'b1, 5'h1f};
      tick();
      ds_wr = 1'b0;
      `CHK(rd_a, 8'h5a)
      wr_pair(PTR_BASE_REG + 5'h04, 16'h1230);
      {ptr_sel, ptr_disp, rd_a_idx} = {2'h2, 6'h05, 5'h1e};
      ptr_mode = PTR_DISP;
      #1;
      `CHK(ptr_addr, 16'h1235)
      tick();
      ptr_mode = PTR_POSTINC;
      #1;
      `CHK(ptr_addr, 16'h1230)
      tick();
      ptr_mode = PTR_NONE;
      `CHK(rd_word, 16'h1231)
      tick();
      ptr_mode = PTR_PREDEC;
      #1;
      `CHK(ptr_addr, 16'h1230)
      tick();
      ptr_mode = PTR_NONE;
      `CHK(rd_word, 16'h1230)
      wr_pair(5'h02, 16'h0008);
      {rd_a_idx, bit_sel} = {5'h02, 3'h3};
      step(I_BST, -1);
      `CHK(flag_register[BIT_TCOPY], 1'b1)
      {rd_a_idx, bit_sel} = {5'h03, 3'h7};
      step(I_BLD, -1);
      `CHK(rd_a, 8'h80)
      {irq_enable, irq_level_type} = {8'hff, 8'h08};
      pulse(8'h04);
      step(I_DONE, -1);
      `CHK(irq_flag, 8'h04)
      step(I_SEI, -1);
      step(I_DONE, -1);
      step(I_DONE, 2);
      `CHK(irq_flag, 8'h00)
      pulse(8'h22);
      step(I_IRQ_RETURN_INSN, -1);
      exp_sp = exp_sp + SP_STEP_ADDR;
      `CHK(stack_pointer, exp_sp)
      step(I_DONE, -1);
      step(I_DONE, 1);
      `CHK(irq_flag, 8'h20)
      step(I_SEI, -1);
      step(I_DONE, -1);
      step(I_CLI, -1);
      step(I_DONE, -1);
      irq_flag_wr1c = 8'h20;
      tick();
      irq_flag_wr1c = '0;
      tick();
      `CHK(irq_flag, 8'h00)
      cond = 8'h08;
      tick(2);
      cond = 8'h00;
      tick(2);
      step(I_SEI, -1);
      step(I_DONE, -1);
      step(I_DONE, -1);
      cond = 8'h08;
      tick(2);
      step(I_DONE, 3);
      cond = 8'h00;
      {vector_relocate_select, sleeping} = 2'b11;
      pulse(8'h01);
      step(I_SEI, -1);
      step(I_DONE, -1);
      step(I_DONE, 0);
      {vector_relocate_select, sleeping} = 2'b00;
      {boot_lock_bit_a, boot_lock_bit_b} = {pc < BOOT_START, pc >= BOOT_START};
      pulse(8'h02);
      step(I_SEI, -1);
      repeat (3) step(I_DONE, -1);
      {boot_lock_bit_a, boot_lock_bit_b} = 2'b00;
      step(I_DONE, 1);
      boot_lock_bit_a = 1'b1;
      pulse(8'h02);
      step(I_IRQ_RETURN_INSN, -1);
      exp_sp = exp_sp + SP_STEP_ADDR;
      repeat (3) step(I_DONE, -1);
      boot_lock_bit_a = 1'b0;
      step(I_DONE, 1);
      `CHK(vq.size() + sq.size() + cq.size(), 0)
      end_of_test();
   end
endmodule // cfsic_core_ctrl_test
